/* File: etc_consts.vh */
// Functional notes
// - after reset the timer is in periodic interrupt mode
// - enable bit starts the counter, advancing on prescaled ticks
// - periodic mode counts to compare value, restarts, flags and pulses event
// - compare below count lets counter run to max and wrap
// - time-out mode starts on first edge, stops on next; polarity picks
// - time-out reaching compare before stop edge flags and pulses event
// - frozen time-out restarts on new start edge; reads and run writes inert
// - snapshot mode free runs, copies count on selected edge, flags
// - reading compare low byte clears the flag in snapshot modes
// - frequency mode snapshots count and restarts on selected edge
// - pulse-width mode restarts on rise, snapshots on fall, then flags
// - combined mode: start rise, snapshot fall, stop and flag second rise
// - single-shot output low when stopped, high while counting after event
// - single-shot stops at compare, holds low one tick, ignores events
// - synchronous single-shot output rises five clocks after the event input rises
// - single-shot counts on enable even without event
// - immediate output mode sets output at once with rising-edge polarity; count starts five clocks later
// - pwm counts zero to low byte, output set at zero, cleared at high byte
// - events act only while event input enable is set
`ifndef ETC_CONSTS_VH
`define ETC_CONSTS_VH
`define ETC_ADDR_CTRL_A     4'h0
`define ETC_ADDR_CTRL_B     4'h1
`define ETC_ADDR_EVSETUP    4'h2
`define ETC_ADDR_STATUS     4'h3
`define ETC_ADDR_FLAGS      4'h4
`define ETC_ADDR_CNT_L      4'h5
`define ETC_ADDR_CNT_H      4'h6
`define ETC_ADDR_CMP_L      4'h7
`define ETC_ADDR_CMP_H      4'h8
`define ETC_BIT_ENABLE      0
`define ETC_BIT_TSEL_LO     1
`define ETC_BIT_TSEL_HI     2
`define ETC_BIT_OUT_EN      4
`define ETC_BIT_OUT_INIT    5
`define ETC_BIT_IMMEDIATE   6
`define ETC_BIT_EV_EN       0
`define ETC_BIT_EDGE        4
`define ETC_MODE_PERIODIC   3'h0
`define ETC_MODE_TIMEOUT    3'h1
`define ETC_MODE_SNAP       3'h2
`define ETC_MODE_FREQ       3'h3
`define ETC_MODE_PW         3'h4
`define ETC_MODE_FPW        3'h5
`define ETC_MODE_SHOT       3'h6
`define ETC_MODE_PWM        3'h7
`define ETC_RESET_CTRL_A    8'h00
`define ETC_RESET_CTRL_B    8'h00
`define ETC_CNT_MAX         16'hFFFF
`define ETC_SYNC_DELAY      2
`endif

/* File: etc_edge_detect.v */
`timescale 1ns/1ps
// two-flop synchroniser then edge detect on the event input
module etc_edge_detect (
    input  wire core_clk,
    input  wire sys_rst,
    input  wire ev_in,
    output wire rise,
    output wire fall
);
    reg  meta;
    reg  sync;
    reg  last;

    // meta is read only by sync
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= ev_in;
            sync <= meta;
            last <= sync;
        end
    end

    assign rise = sync & ~last;
    assign fall = ~sync & last;
endmodule // etc_edge_detect

/* File: etc_event_src.sv */
`timescale 1ns/1ps
module etc_event_src (
    input  wire  core_clk,
    output logic event_in
);
    initial event_in = 1'b0;
    // one event: hi clocks high (at least 2), lo clocks low; idles low
    task automatic pulse(input int hi, input int lo);
        if (hi < 2) hi = 2;
        event_in <= 1'b1;
        repeat (hi) @(posedge core_clk);
        event_in <= 1'b0;
        repeat (lo) @(posedge core_clk);
    endtask
endmodule // etc_event_src

/* File: etc_prescaler.v */
`timescale 1ns/1ps
// tick enable: every clock, every second clock, or every fourth (or external tick)
module etc_prescaler (
    input  wire       core_clk,
    input  wire       sys_rst,
    input  wire       run_en,
    input  wire [1:0] sel,
    input  wire       ext_tick,
    output wire       tick
);
    reg  [1:0] div;

    // divider only runs while enabled so the first tick is predictable
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div <= 2'h0;
        end else if (!run_en) begin
            div <= 2'h0;
        end else begin
            div <= div + 2'h1;
        end
    end

    assign tick = run_en & ((sel == 2'h0) ? 1'b1 :
                            (sel == 2'h1) ? div[0] :
                            (sel == 2'h2) ? (div == 2'h3) : ext_tick);
endmodule // etc_prescaler

/* File: etc_timer.v */
`timescale 1ns/1ps
`include "etc_consts.vh"
module etc_timer (
    input  wire        core_clk,
    input  wire        sys_rst,
    input  wire [3:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    input  wire        event_in,
    input  wire        ext_tick,
    output wire        wave_out,
    output reg         event_pulse
);
    reg  [7:0]  control_word_a;
    reg  [7:0]  control_word_b;
    reg  [7:0]  event_setup_reg;
    reg  [15:0] count_register;
    reg  [15:0] compare_snapshot_reg;
    reg         snapshot_flag;
    reg         running;
    reg         armed;
    reg         pw_phase;
    reg         fpw_done;
    reg         shot_hold;
    reg         shot_out;
    reg         pwm_out;
    reg         async_out;
    reg  [1:0]  shot_dly;
    reg         shot_pend;
    reg         async_clr;
    wire        tick;
    wire        ev_rise;
    wire        ev_fall;
    wire [2:0]  mode;
    wire        enabled;
    wire        edge_sel;
    wire        ev_ok;
    wire        ev_start;
    wire        ev_stop;
    wire        at_cmp;
    wire        wr_cnt_l;
    wire        wr_cnt_h;
    wire        rd_cmp_l;
    wire        frozen_to;
    reg         next_flag;
    reg         next_pulse;

    assign mode     = control_word_b[2:0];
    assign enabled  = control_word_a[`ETC_BIT_ENABLE];
    assign edge_sel = event_setup_reg[`ETC_BIT_EDGE];
    assign ev_ok    = enabled & event_setup_reg[`ETC_BIT_EV_EN];
    // edge polarity bit swaps which edge starts and which stops
    assign ev_start = ev_ok & (edge_sel ? ev_fall : ev_rise);
    assign ev_stop  = ev_ok & (edge_sel ? ev_rise : ev_fall);
    assign at_cmp   = (count_register == compare_snapshot_reg);
    assign wr_cnt_l = reg_wr & (reg_addr == `ETC_ADDR_CNT_L);
    assign wr_cnt_h = reg_wr & (reg_addr == `ETC_ADDR_CNT_H);
    assign frozen_to = (mode == `ETC_MODE_TIMEOUT) & ~running;
    // reading the low snapshot byte is a side effect, inert while frozen
    assign rd_cmp_l = reg_rd & (reg_addr == `ETC_ADDR_CMP_L) & ~frozen_to;

    etc_prescaler u_presc (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .run_en   (enabled),
        .sel      (control_word_a[`ETC_BIT_TSEL_HI:`ETC_BIT_TSEL_LO]),
        .ext_tick (ext_tick),
        .tick     (tick)
    );

    etc_edge_detect u_edge (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .ev_in    (event_in),
        .rise     (ev_rise),
        .fall     (ev_fall)
    );

    // configuration registers; mode field resets to periodic
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            control_word_a  <= `ETC_RESET_CTRL_A;
            control_word_b  <= `ETC_RESET_CTRL_B;
            event_setup_reg <= 8'h00;
        end else if (reg_wr) begin
            case (reg_addr)
                `ETC_ADDR_CTRL_A:  control_word_a  <= reg_wdata;
                `ETC_ADDR_CTRL_B:  control_word_b  <= reg_wdata;
                `ETC_ADDR_EVSETUP: event_setup_reg <= reg_wdata;
                default: ;
            endcase
        end
    end

    // flag: set beats the low-byte read clear
    always @* begin
        next_flag  = snapshot_flag;
        next_pulse = 1'b0;
        if (rd_cmp_l && mode >= `ETC_MODE_SNAP && mode <= `ETC_MODE_FPW) begin
            next_flag = 1'b0;
        end
        if (reg_wr && reg_addr == `ETC_ADDR_FLAGS && reg_wdata[0]) begin
            next_flag = 1'b0;
        end
        case (mode)
            `ETC_MODE_PERIODIC: begin
                if (tick && at_cmp) begin
                    next_flag  = 1'b1;
                    next_pulse = 1'b1;
                end
            end
            `ETC_MODE_TIMEOUT: begin
                if (tick && running && at_cmp && !ev_stop) begin
                    next_flag  = 1'b1;
                    next_pulse = 1'b1;
                end
            end
            `ETC_MODE_SNAP, `ETC_MODE_FREQ: begin
                if (ev_start) begin
                    next_flag  = 1'b1;
                    next_pulse = 1'b1;
                end
            end
            `ETC_MODE_PW: begin
                if (ev_ok && pw_phase && ev_fall) begin
                    next_flag  = 1'b1;
                    next_pulse = 1'b1;
                end
            end
            `ETC_MODE_FPW: begin
                if (ev_ok && ev_rise && running && pw_phase) begin
                    next_flag  = 1'b1;
                    next_pulse = 1'b1;
                end
            end
            `ETC_MODE_SHOT, `ETC_MODE_PWM: begin
                if (tick && at_cmp && running) begin
                    next_flag  = 1'b1;
                    next_pulse = 1'b1;
                end
            end
            default: ;
        endcase
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            snapshot_flag <= 1'b0;
            event_pulse   <= 1'b0;
        end else begin
            snapshot_flag <= next_flag;
            event_pulse   <= next_pulse;
        end
    end

    // counter, snapshot register and per-mode sequencing
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_register       <= 16'h0000;
            compare_snapshot_reg <= 16'h0000;
            running              <= 1'b0;
            armed                <= 1'b0;
            pw_phase             <= 1'b0;
            fpw_done             <= 1'b0;
            shot_hold            <= 1'b0;
            shot_out             <= 1'b0;
            shot_dly             <= 2'h0;
            shot_pend            <= 1'b0;
            pwm_out              <= 1'b0;
        end else begin
            armed <= enabled;
            if (!enabled) begin
                running  <= 1'b0;
                shot_out <= 1'b0;
                pwm_out  <= 1'b0;
                pw_phase <= 1'b0;
                fpw_done <= 1'b0;
            end else begin
                case (mode)
                    `ETC_MODE_PERIODIC: begin
                        if (tick) begin
                            // past compare: runs on to max and wraps
                            count_register <= at_cmp ? 16'h0000
                                                     : count_register + 16'h0001;
                        end
                    end
                    `ETC_MODE_TIMEOUT: begin
                        if (ev_start && !running) begin
                            running        <= 1'b1;
                            count_register <= 16'h0000;
                        end else if (ev_stop && running) begin
                            running <= 1'b0;
                        end else if (tick && running) begin
                            count_register <= at_cmp ? 16'h0000
                                                     : count_register + 16'h0001;
                        end
                    end
                    `ETC_MODE_SNAP: begin
                        if (ev_start) begin
                            compare_snapshot_reg <= count_register;
                        end
                        if (tick) begin
                            count_register <= count_register + 16'h0001;
                        end
                    end
                    `ETC_MODE_FREQ: begin
                        if (ev_start) begin
                            compare_snapshot_reg <= count_register;
                            count_register       <= 16'h0000;
                        end else if (tick) begin
                            count_register <= count_register + 16'h0001;
                        end
                    end
                    `ETC_MODE_PW: begin
                        // phase toggles between restart and capture
                        if (ev_ok && !pw_phase && ev_rise) begin
                            count_register <= 16'h0000;
                            pw_phase       <= 1'b1;
                        end else if (ev_ok && pw_phase && ev_fall) begin
                            compare_snapshot_reg <= count_register;
                            pw_phase             <= 1'b0;
                        end else if (tick) begin
                            count_register <= count_register + 16'h0001;
                        end
                    end
                    `ETC_MODE_FPW: begin
                        if (fpw_done) begin
                            if (!snapshot_flag) begin
                                fpw_done <= 1'b0; // re-armed by snapshot read
                            end
                        end else if (ev_ok && ev_rise && !running) begin
                            count_register <= 16'h0000;
                            running        <= 1'b1;
                            pw_phase       <= 1'b0;
                        end else if (ev_ok && ev_fall && running && !pw_phase) begin
                            compare_snapshot_reg <= count_register;
                            pw_phase             <= 1'b1;
                            count_register       <= count_register + {15'h0000, tick};
                        end else if (ev_ok && ev_rise && running && pw_phase) begin
                            running  <= 1'b0;
                            fpw_done <= 1'b1;
                        end else if (tick && running) begin
                            count_register <= count_register + 16'h0001;
                        end
                    end
                    `ETC_MODE_SHOT: begin
                        if (!armed && !at_cmp) begin
                            running   <= 1'b1;
                            shot_pend <= 1'b0;
                        end
                        if (shot_pend) begin
                            // event seen: start after the fixed delay
                            if (shot_dly == `ETC_SYNC_DELAY - 1) begin
                                shot_pend      <= 1'b0;
                                running        <= 1'b1;
                                count_register <= 16'h0000;
                                shot_out       <= 1'b1;
                            end else begin
                                shot_dly <= shot_dly + 2'h1;
                            end
                        end else if (shot_hold) begin
                            if (tick) begin
                                shot_hold <= 1'b0;
                            end
                        end else if (ev_start && !running) begin
                            shot_pend <= 1'b1;
                            shot_dly  <= 2'h0;
                        end else if (running && tick) begin
                            if (at_cmp) begin
                                running   <= 1'b0;
                                shot_out  <= 1'b0;
                                shot_hold <= 1'b1;
                            end else begin
                                count_register <= count_register + 16'h0001;
                                shot_out       <= 1'b1;
                            end
                        end
                    end
                    `ETC_MODE_PWM: begin
                        running <= 1'b1;
                        if (tick) begin
                            if (count_register[7:0] == compare_snapshot_reg[7:0]) begin
                                count_register <= 16'h0000;
                                pwm_out        <= 1'b1;
                            end else begin
                                count_register <= count_register + 16'h0001;
                                if (count_register[7:0] + 8'h01 == compare_snapshot_reg[15:8]) begin
                                    pwm_out <= 1'b0;
                                end
                            end
                        end
                    end
                    default: ;
                endcase
            end
            // software writes to count and compare take priority
            if (wr_cnt_l) begin
                count_register[7:0] <= reg_wdata;
            end
            if (wr_cnt_h) begin
                count_register[15:8] <= reg_wdata;
            end
            if (reg_wr && reg_addr == `ETC_ADDR_CMP_L) begin
                compare_snapshot_reg[7:0] <= reg_wdata;
            end
            if (reg_wr && reg_addr == `ETC_ADDR_CMP_H) begin
                compare_snapshot_reg[15:8] <= reg_wdata;
            end
            if (reg_wr && reg_addr == `ETC_ADDR_STATUS && !frozen_to) begin
                running <= reg_wdata[0];
            end
        end
    end

    // keeps the raw-event flop clear unless a shot waits
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            async_clr <= 1'b1;
        end else begin
            async_clr <= ~(ev_ok & ~edge_sel & (mode == `ETC_MODE_SHOT)
                           & ~running & ~shot_hold & control_word_b[`ETC_BIT_IMMEDIATE]);
        end
    end

    // immediate output: set by the raw event, not the synchronised one
    always @(posedge event_in or posedge async_clr) begin
        if (async_clr) begin
            async_out <= 1'b0;
        end else begin
            async_out <= 1'b1;
        end
    end

    // output mux; stopped single-shot drives low
    assign wave_out = ~control_word_b[`ETC_BIT_OUT_EN] ? 1'b0 :
                      (mode == `ETC_MODE_SHOT) ? (shot_out |
                          (control_word_b[`ETC_BIT_IMMEDIATE] & async_out)) :
                      (mode == `ETC_MODE_PWM) ? pwm_out :
                      control_word_b[`ETC_BIT_OUT_INIT];

    // read data one cycle after the strobe
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `ETC_ADDR_CTRL_A:  reg_rdata <= control_word_a;
                `ETC_ADDR_CTRL_B:  reg_rdata <= control_word_b;
                `ETC_ADDR_EVSETUP: reg_rdata <= event_setup_reg;
                `ETC_ADDR_STATUS:  reg_rdata <= {7'h00, running};
                `ETC_ADDR_FLAGS:   reg_rdata <= {7'h00, snapshot_flag};
                `ETC_ADDR_CNT_L:   reg_rdata <= count_register[7:0];
                `ETC_ADDR_CNT_H:   reg_rdata <= count_register[15:8];
                `ETC_ADDR_CMP_L:   reg_rdata <= compare_snapshot_reg[7:0];
                `ETC_ADDR_CMP_H:   reg_rdata <= compare_snapshot_reg[15:8];
                default:           reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule // etc_timer

/* File: etc_timer_sva.sv */
`timescale 1ns/1ps
`include "etc_consts.vh"
module etc_timer_sva (
    input wire       core_clk,
    input wire       sys_rst,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       event_in,
    input wire       ext_tick,
    input wire       wave_out,
    input wire       event_pulse
);
    reg  [7:0] sh_a;
    reg  [7:0] sh_b;
    reg  [7:0] sh_ev;
    reg        en_d;
    reg        ev_d;
    reg  [2:0] low_run;
    wire       en    = sh_a[`ETC_BIT_ENABLE];
    wire       ev_on = sh_ev[`ETC_BIT_EV_EN];
    wire [2:0] mode  = sh_b[2:0];
    wire       meas  = (mode >= `ETC_MODE_SNAP) && (mode <= `ETC_MODE_FPW);
    wire       shot  = (mode == `ETC_MODE_SHOT) && en && ev_on && !sh_ev[`ETC_BIT_EDGE];
    // shadow control bytes; only the bus is visible here
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sh_a    <= `ETC_RESET_CTRL_A;
            sh_b    <= `ETC_RESET_CTRL_B;
            sh_ev   <= 8'h00;
            en_d    <= 1'b0;
            ev_d    <= 1'b0;
            low_run <= 3'h0;
        end else begin
            if (reg_wr && reg_addr == `ETC_ADDR_CTRL_A) sh_a <= reg_wdata;
            if (reg_wr && reg_addr == `ETC_ADDR_CTRL_B) sh_b <= reg_wdata;
            if (reg_wr && reg_addr == `ETC_ADDR_EVSETUP) sh_ev <= reg_wdata;
            en_d    <= en;
            ev_d    <= ev_on;
            // saturating low-time count
            low_run <= wave_out ? 3'h0 : low_run + {2'h0, low_run != 3'h7};
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_reset_quiet: assert property ($past(sys_rst) |-> !event_pulse && !wave_out)
        else $error("outputs not quiet after reset");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_idle_silent: assert property (!en && !en_d |-> !event_pulse)
        else $error("event pulse while disabled");
    a_event_gate: assert property (meas && !ev_on && !ev_d |-> !event_pulse)
        else $error("event acted while event input off");
    a_pulse_single: assert property (meas && event_pulse |=> !event_pulse)
        else $error("event pulse longer than one cycle");
    a_snap_latency: assert property ((mode == `ETC_MODE_SNAP) && en && ev_on
        && !sh_ev[`ETC_BIT_EDGE] && $rose(event_in) |-> ##[2:6] event_pulse)
        else $error("no snapshot pulse after event");
    a_shot_start: assert property (shot && !sh_b[`ETC_BIT_IMMEDIATE]
        && low_run == 3'h7 && $rose(event_in) |-> ##[2:7] wave_out)
        else $error("single shot did not start");
    a_shot_async: assert property (shot && sh_b[`ETC_BIT_IMMEDIATE]
        && low_run == 3'h7 && $rose(event_in) |-> wave_out)
        else $error("immediate output not set at event");
    a_shot_idle: assert property ((mode == `ETC_MODE_SHOT) && !en && !en_d
        && !sh_b[`ETC_BIT_IMMEDIATE] |-> !wave_out)
        else $error("single shot output high while stopped");
    c_snap: cover property ((mode == `ETC_MODE_SNAP) && event_pulse);
    c_shot: cover property ((mode == `ETC_MODE_SHOT) && $rose(wave_out));
    c_pwm: cover property ((mode == `ETC_MODE_PWM) && $rose(wave_out));
endmodule // etc_timer_sva
bind etc_timer etc_timer_sva etc_timer_sva_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .event_in(event_in), .ext_tick(ext_tick),
    .wave_out(wave_out), .event_pulse(event_pulse));

/* File: event_timer_capture_unit_tb.sv */
`timescale 1ns/1ps
`include "etc_consts.vh"
module event_timer_capture_unit_tb;
    logic       core_clk  = 1'b0;
    logic       sys_rst   = 1'b1;
    logic [3:0] reg_addr  = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    logic       ext_tick  = 1'b0;
    logic [1:0] tdiv      = 2'h0;
    logic [7:0] v;
    wire  [7:0] reg_rdata;
    wire        event_in;
    wire        wave_out;
    wire        event_pulse;
    int         bad_count = 0;
    int         n_tests   = 0;
    int         n;
    int         mult[4]   = '{1, 2, 4, 3};
    etc_timer etc_timer_i (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .event_in(event_in), .ext_tick(ext_tick), .wave_out(wave_out),
        .event_pulse(event_pulse));
    etc_event_src etc_event_src_i (.core_clk(core_clk), .event_in(event_in));
    always #50 core_clk = ~core_clk;
    // external tick once every third clock
    always @(posedge core_clk) begin
        tdiv <= (tdiv == 2'h2) ? 2'h0 : tdiv + 2'h1;
        ext_tick <= (tdiv == 2'h2);
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // an idle cycle after each access keeps strobes apart
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge core_clk);
    endtask
    task automatic setup(input logic [7:0] b, input logic [7:0] ev);
        wr(`ETC_ADDR_CTRL_B, b);
        wr(`ETC_ADDR_EVSETUP, ev);
        wr(`ETC_ADDR_FLAGS, 8'h01);
        wr(`ETC_ADDR_CTRL_A, 8'h01);
    endtask
    task automatic till(output int i);
        i = 0;
        while (event_pulse !== 1'b1 && i < 70000) begin
            @(posedge core_clk);
            i++;
        end
        if (i >= 70000) bad_count++;
    endtask
    task automatic gap(output int p);
        till(p);
        @(posedge core_clk);
        till(p);
        p = p + 1;
    endtask
    task automatic count_hi(input int c, output int h);
        h = 0;
        repeat (c) begin
            @(posedge core_clk);
            if (wave_out === 1'b1) h++;
        end
    endtask
    // stimulus, mode after mode
    initial begin
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        rd(`ETC_ADDR_CTRL_B, v);
        chk({13'h0, v[2:0]}, {13'h0, `ETC_MODE_PERIODIC});
        rd(4'hF, v);
        chk({8'h00, v}, 16'h0000);
        wr(`ETC_ADDR_CMP_L, 8'h05);
        wr(`ETC_ADDR_CMP_H, 8'h00);
        for (int t = 0; t < 4; t++) begin
            wr(`ETC_ADDR_CTRL_A, 8'(t * 2 + 1));
            gap(n);
            gap(n);
            chk(16'(n), 16'(mult[t] * 6));
        end
        rd(`ETC_ADDR_FLAGS, v);
        chk({15'h0, v[0]}, 16'h0001);
        wr(`ETC_ADDR_CTRL_A, 8'h01);
        wr(`ETC_ADDR_CMP_L, 8'hC8);
        till(n);
        repeat (50) @(posedge core_clk);
        wr(`ETC_ADDR_CMP_L, 8'h0A);
        till(n);
        chk({15'h0, n > 65000}, 16'h0001);
        wr(`ETC_ADDR_CTRL_A, 8'h00);
        wr(`ETC_ADDR_CNT_L, 8'h00);
        wr(`ETC_ADDR_CNT_H, 8'h00);
        setup({5'h00, `ETC_MODE_SNAP}, 8'h01);
        etc_event_src_i.pulse(3, 10);
        rd(`ETC_ADDR_FLAGS, v);
        chk({15'h0, v[0]}, 16'h0001);
        rd(`ETC_ADDR_CMP_L, v);
        rd(`ETC_ADDR_FLAGS, v);
        chk({15'h0, v[0]}, 16'h0000);
        wr(`ETC_ADDR_EVSETUP, 8'h00);
        etc_event_src_i.pulse(3, 10);
        rd(`ETC_ADDR_FLAGS, v);
        chk({15'h0, v[0]}, 16'h0000);
        wr(`ETC_ADDR_CTRL_A, 8'h00);
        setup({5'h00, `ETC_MODE_FREQ}, 8'h01);
        repeat (3) etc_event_src_i.pulse(3, 17);
        rd(`ETC_ADDR_CMP_L, v);
        chk({15'h0, v == 8'h13 || v == 8'h14}, 16'h0001);
        setup({5'h00, `ETC_MODE_FPW}, 8'h01);
        repeat (2) etc_event_src_i.pulse(4, 6);
        rd(`ETC_ADDR_CNT_L, v);
        chk({15'h0, v == 8'h09 || v == 8'h0A}, 16'h0001);
        rd(`ETC_ADDR_CMP_L, v);
        chk({15'h0, v == 8'h03 || v == 8'h04}, 16'h0001);
        for (int k = 0; k < 2; k++) begin
            wr(`ETC_ADDR_CTRL_A, 8'h00);
            wr(`ETC_ADDR_CMP_L, 8'h0A);
            wr(`ETC_ADDR_CNT_L, 8'h0A);
            wr(`ETC_ADDR_CNT_H, 8'h00);
            setup(k ? 8'h56 : 8'h16, 8'h01);
            count_hi(10, n);
            chk(16'(n), 16'h0000);
            fork
                etc_event_src_i.pulse(3, 30);
                count_hi(30, n);
            join
            chk({15'h0, n >= 10 + 5 * k && n <= 14 + 5 * k}, 16'h0001);
        end
        wr(`ETC_ADDR_CTRL_A, 8'h00);
        wr(`ETC_ADDR_CNT_L, 8'h00);
        setup(8'h16, 8'h00);
        count_hi(5, n);
        chk({15'h0, n > 2}, 16'h0001);
        wr(`ETC_ADDR_CTRL_A, 8'h00);
        wr(`ETC_ADDR_CMP_L, 8'h09);
        wr(`ETC_ADDR_CMP_H, 8'h03);
        setup(8'h17, 8'h00);
        count_hi(20, n);
        count_hi(100, n);
        chk(16'(n), 16'h001E);
        results();
    end
    // watchdog: wrap scenario plus margin
    initial begin
        #10000000;
        bad_count++;
        results();
    end
endmodule // event_timer_capture_unit_tb
